// [hw/ira_arbiter.sv]
/*
  interrupt request arbiter: per-source control registers, mask
  collections, in-service levels, nonmaskable, trap and software break
  handling, and acceptance towards the core.
  assumes peripherals, core and register master share CLK_SYS;
  the nonmaskable pin is asynchronous.
*/
// Notes on behaviour
// [RQ1] nonmaskable from pin or watchdog, ignores enable
// [RQ2] nonmaskable bypasses levels, wins over all
// [RQ3] nonmaskable held only by same/higher busy
// [RQ4] maskable needs mask clear and global enable
// [RQ5] equal level: lowest fixed order wins
// [RQ6] four programmable levels control nesting
// [RQ7] macro service ignores levels and enable
// [RQ8] per source: vectored, bank switch or macro
// [RQ9] break vectored, break bank switch, always taken
// [RQ10] bad protected write raises op-code trap
// [RQ11] trap taken when disabled, no levels
// [RQ12] vectored: push counter and status, jump
// [RQ13] return instruction ends handler, restores context
// [RQ14] macro service: no context save or restore
// [RQ15] bank switch: select bank, save, jump
// [RQ16] serial channel 1 done: fixed addresses
// [RQ17] one control register per maskable source
// [RQ18] mask collections mirror per-source masks
// [RQ19] in-service register records handled levels
// [RQ20] mode register allows level 3 nesting
// [RQ21] level 0 most urgent, 3 least
// [RQ22] flag set on request, cleared on acceptance
// [RQ23] mask clear plus macro: macro then vectored
// [RQ24] preempt only when strictly more urgent
`timescale 1ns/10ps
`default_nettype none
module ira_arbiter
(
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic [7:0] ADDR,
  input wire logic [15:0] WR_DATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  output logic [15:0] RD_DATA,
  input wire logic [23:0] SRC_REQ,
  input wire logic NMI_PIN,
  input wire logic WDT_OVF,
  input wire logic PROT_WR_FAIL,
  input wire logic BRK_EXEC,
  input wire logic SOFT_BREAK_BANK_SWITCH_EXEC,
  input wire logic HANDLER_RETURN_INSTR_EXEC,
  input wire logic GLOBAL_INT_ENABLE,
  input wire logic VECTOR_TABLE_SELECT,
  input wire logic CORE_READY,
  input wire logic MS_END,
  input wire logic [4:0] MS_END_SRC,
  output logic ACC_STB,
  output logic [1:0] ACC_KIND,
  output logic [4:0] ACC_SRC,
  output logic [15:0] ACC_VECTOR,
  output logic [15:0] ACC_MSCW,
  output logic ACC_PUSH
);
  // ****************************************
  // functions
  // ****************************************
  function automatic logic [5:0] pick_src(input logic [23:0] elig,
                                          input logic [23:0][1:0] lv);
    logic [5:0] r;
    r = 6'h00;
    for (int l = 3; l >= 0; l--)
      for (int i = 23; i >= 0; i--)
        if (elig[i] && lv[i] == 2'(l))
          r = {1'b1, 5'(i)};
    return r;
  endfunction

  function automatic logic level_ok(input logic [1:0] lv, input logic [3:0] isp,
                                    input logic nest, input logic nbusy);
    logic ok;
    ok = !nbusy;
    for (int k = 0; k < 4; k++)
      if (isp[k] && int'(lv) >= k && !(k == 3 && nest))
        ok = 1'b0;
    return ok;
  endfunction

  function automatic logic [15:0] vec_of(input logic [4:0] code, input logic vector_table_select);
    logic [15:0] v;
    case (code)
      ira_pkg::SRC_NMI: v = ira_pkg::VEC_NMI;
      ira_pkg::SRC_WDT: v = ira_pkg::VEC_WDT;
      ira_pkg::SRC_TRAP: v = ira_pkg::VEC_TRAP;
      ira_pkg::SRC_BRK: v = ira_pkg::VEC_BRK;
      ira_pkg::SRC_SOFT_BREAK_BANK_SWITCH: v = ira_pkg::VEC_BRK;
      default: v = ira_pkg::VEC_MASK_BASE + {10'h000, code, 1'b0};
    endcase
    return vector_table_select ? (v | ira_pkg::VEC_HI_TABLE) : v;
  endfunction

  // ****************************************
  // state
  // ****************************************
  logic [23:0] req_flag;
  logic [23:0] source_mask;
  logic [23:0] macro_service_select;
  logic [23:0] bank_switch_enable;
  logic [23:0][1:0] level_field;
  logic [3:0] in_service_levels;
  logic nesting_mode_ctrl;
  logic [1:0] nmi_pend;
  logic [1:0] nmi_busy;
  logic trap_pend;
  logic brk_pend;
  logic soft_break_bank_switch_pend;
  logic nmi_sync;
  logic nmi_sync_q;
  logic [23:0] next_flag;
  logic [23:0] next_mask;
  logic [23:0] next_ism;
  logic [23:0] next_cse;
  logic [23:0][1:0] next_lvl;
  logic [23:0] eligible;
  logic [23:0] take_clr;

  ira_pin_sync u_nmi_sync
  (
    .clk(CLK_SYS),
    .rst_b(RST_B),
    .pin(NMI_PIN),
    .sync(nmi_sync)
  );

  // ****************************************
  // register decode
  // ****************************************
  wire wr_ctrl = WR_STB && ADDR < 8'(ira_pkg::NSRC);
  wire wr_mlo = WR_STB && ADDR == ira_pkg::ADDR_MASK_LO;
  wire wr_mhi = WR_STB && ADDR == ira_pkg::ADDR_MASK_HI;
  wire [2:0] wr_mb = {WR_STB && ADDR == ira_pkg::ADDR_MASK_B2,
                      WR_STB && ADDR == ira_pkg::ADDR_MASK_B1,
                      WR_STB && ADDR == ira_pkg::ADDR_MASK_B0};
  wire wr_imc = WR_STB && ADDR == ira_pkg::ADDR_IMC;

  // ****************************************
  // arbitration
  // ****************************************
  wire nmi_any_busy = |nmi_busy;
  wire can_take = CORE_READY && !ACC_STB;
  // [RQ3] nonmaskable hold rank
  wire pin_ok = nmi_pend[0] && !nmi_busy[0];
  wire wdt_ok = nmi_pend[1] && !nmi_any_busy && !pin_ok;
  // [RQ5] lowest fixed order wins
  wire [5:0] pick = pick_src(eligible, level_field);
  wire found = pick[5];
  wire [4:0] sidx = pick[4:0];
  wire cand_ism = macro_service_select[sidx];
  wire cand_mask = source_mask[sidx];
  wire [1:0] cand_lvl = level_field[sidx];
  // [RQ2] fixed order of kinds
  wire [4:0] next_src = pin_ok ? ira_pkg::SRC_NMI :
                        wdt_ok ? ira_pkg::SRC_WDT :
                        trap_pend ? ira_pkg::SRC_TRAP :
                        brk_pend ? ira_pkg::SRC_BRK :
                        soft_break_bank_switch_pend ? ira_pkg::SRC_SOFT_BREAK_BANK_SWITCH : sidx;
  wire any_req = pin_ok || wdt_ok || trap_pend || brk_pend || soft_break_bank_switch_pend || found;
  wire go = can_take && any_req;
  wire soft_or_nmi = pin_ok || wdt_ok || trap_pend || brk_pend || soft_break_bank_switch_pend;
  wire take_mask = go && !soft_or_nmi;
  wire go_pin = go && pin_ok;
  wire go_wdt = go && wdt_ok;
  wire go_trap = go && !pin_ok && !wdt_ok && trap_pend;
  wire go_brk = go && !pin_ok && !wdt_ok && !trap_pend && brk_pend;
  wire go_soft_break_bank_switch = go && next_src == ira_pkg::SRC_SOFT_BREAK_BANK_SWITCH;
  // [RQ8] servicing mode per source
  wire [1:0] next_kind = go_soft_break_bank_switch ? ira_pkg::KIND_BANK :
                         !take_mask ? ira_pkg::KIND_VECT :
                         cand_ism ? ira_pkg::KIND_MACRO :
                         bank_switch_enable[sidx] ? ira_pkg::KIND_BANK :
                         ira_pkg::KIND_VECT;
  wire in_service_levels_set_en = take_mask && next_kind != ira_pkg::KIND_MACRO;
  wire [3:0] in_service_levels_set = in_service_levels_set_en ? 4'(4'h1 << cand_lvl) : 4'h0;
  // [RQ13] return releases innermost handler
  wire handler_return_instr_mask = HANDLER_RETURN_INSTR_EXEC && !nmi_any_busy;
  wire [3:0] in_service_levels_low = 4'(in_service_levels & (~in_service_levels + 4'h1));
  wire [3:0] in_service_levels_clr = handler_return_instr_mask ? in_service_levels_low : 4'h0;
  wire [1:0] nmi_clr = !HANDLER_RETURN_INSTR_EXEC ? 2'b00 : nmi_busy[0] ? 2'b01 : nmi_busy[1] ? 2'b10 : 2'b00;
  wire nmi_edge = nmi_sync && !nmi_sync_q;

  genvar g;
  for (g = 0; g < ira_pkg::NSRC; g++)
  begin : gsrc
    wire sel = wr_ctrl && ADDR[4:0] == 5'(g);
    wire ms_raise = MS_END && MS_END_SRC == 5'(g);
    wire mhit = (g < 16 ? wr_mlo : wr_mhi) || wr_mb[g / 8];
    wire mval = wr_mb[g / 8] ? WR_DATA[g % 8] : WR_DATA[g % 16];
    // [RQ22] set wins over clear
    assign next_flag[g] = SRC_REQ[g] || ms_raise ||
                          (sel ? WR_DATA[ira_pkg::BIT_IF] : req_flag[g] && !take_clr[g]);
    // [RQ18] mirrored mask views
    assign next_mask[g] = sel ? WR_DATA[ira_pkg::BIT_MK] : mhit ? mval : source_mask[g];
    // [RQ23] macro end reverts to vectored
    assign next_ism[g] = sel ? WR_DATA[ira_pkg::BIT_ISM] : macro_service_select[g] && !ms_raise;
    assign next_cse[g] = sel ? WR_DATA[ira_pkg::BIT_CSE] : bank_switch_enable[g];
    assign next_lvl[g] = sel ? WR_DATA[1:0] : level_field[g];
    assign take_clr[g] = take_mask && sidx == 5'(g);
    // [RQ4] mask and global enable
    // [RQ7] macro bypasses level and enable
    // [RQ24] strictly more urgent to preempt
    assign eligible[g] = req_flag[g] && !source_mask[g] && (macro_service_select[g] ||
                         (GLOBAL_INT_ENABLE && level_ok(level_field[g], in_service_levels,
                                                       nesting_mode_ctrl, nmi_any_busy)));
  end

  // ****************************************
  // read mux
  // ****************************************
  wire [4:0] ridx = ADDR[4:0];
  wire [15:0] ctrl_rd = {8'h00, req_flag[ridx], source_mask[ridx], macro_service_select[ridx],
                         bank_switch_enable[ridx], 2'b00, level_field[ridx]};
  wire [15:0] rd_mux = ADDR < 8'(ira_pkg::NSRC) ? ctrl_rd :
                       ADDR == ira_pkg::ADDR_MASK_LO ? source_mask[15:0] :
                       ADDR == ira_pkg::ADDR_MASK_HI ? {8'h00, source_mask[23:16]} :
                       ADDR == ira_pkg::ADDR_MASK_B0 ? {8'h00, source_mask[7:0]} :
                       ADDR == ira_pkg::ADDR_MASK_B1 ? {8'h00, source_mask[15:8]} :
                       ADDR == ira_pkg::ADDR_MASK_B2 ? {8'h00, source_mask[23:16]} :
                       ADDR == ira_pkg::ADDR_IN_SERVICE_LEVELS ? {12'h000, in_service_levels} :
                       ADDR == ira_pkg::ADDR_IMC ? {15'h0000, nesting_mode_ctrl} : 16'h0000;

  // ****************************************
  // per-source registers
  // ****************************************
  // [RQ17] control register per source
  // [RQ21] level encoding 0 most urgent
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      req_flag <= 24'h000000;
      source_mask <= 24'hffffff;
      macro_service_select <= 24'h000000;
      bank_switch_enable <= 24'h000000;
      level_field <= {24{ira_pkg::CTRL_RESET[1:0]}};
    end
    else
    begin
      req_flag <= next_flag;
      source_mask <= next_mask;
      macro_service_select <= next_ism;
      bank_switch_enable <= next_cse;
      level_field <= next_lvl;
    end
  end

  // ****************************************
  // pending and in-service state
  // ****************************************
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      in_service_levels <= 4'h0;
      nesting_mode_ctrl <= ira_pkg::IMC_RESET;
      nmi_pend <= 2'b00;
      nmi_busy <= 2'b00;
      trap_pend <= 1'b0;
      brk_pend <= 1'b0;
      soft_break_bank_switch_pend <= 1'b0;
      nmi_sync_q <= 1'b0;
    end
    else
    begin
      // [RQ6] [RQ19] level bookkeeping
      in_service_levels <= (in_service_levels & ~in_service_levels_clr) | in_service_levels_set;
      // [RQ20] level 3 nesting switch
      nesting_mode_ctrl <= wr_imc ? WR_DATA[0] : nesting_mode_ctrl;
      // [RQ1] nonmaskable sources
      nmi_pend <= {WDT_OVF, nmi_edge} | (nmi_pend & ~{go_wdt, go_pin});
      nmi_busy <= (nmi_busy & ~nmi_clr) | {go_wdt, go_pin};
      // [RQ10] [RQ11] op-code trap
      trap_pend <= PROT_WR_FAIL || (trap_pend && !go_trap);
      // [RQ9] software breaks
      brk_pend <= BRK_EXEC || (brk_pend && !go_brk);
      soft_break_bank_switch_pend <= SOFT_BREAK_BANK_SWITCH_EXEC || (soft_break_bank_switch_pend && !go_soft_break_bank_switch);
      nmi_sync_q <= nmi_sync;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      RD_DATA <= 16'h0000;
      ACC_STB <= 1'b0;
      ACC_KIND <= ira_pkg::KIND_VECT;
      ACC_SRC <= 5'h00;
      ACC_VECTOR <= 16'h0000;
      ACC_MSCW <= 16'h0000;
      ACC_PUSH <= 1'b0;
    end
    else
    begin
      RD_DATA <= RD_STB ? rd_mux : 16'h0000;
      ACC_STB <= go;
      ACC_KIND <= next_kind;
      ACC_SRC <= next_src;
      // [RQ16] vector and control word
      ACC_VECTOR <= vec_of(next_src, VECTOR_TABLE_SELECT);
      ACC_MSCW <= ira_pkg::MSCW_BASE + {10'h000, sidx, 1'b0};
      // [RQ12] [RQ14] [RQ15] context save
      ACC_PUSH <= go && next_kind == ira_pkg::KIND_VECT;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);

  sequence nmi_go_s;
    go_pin;
  endsequence
  sequence nmi_acc_s;
    ACC_STB && ACC_SRC == ira_pkg::SRC_NMI && ACC_PUSH ##1 !ACC_STB;
  endsequence
  nmi_wins_a: assert property (nmi_go_s |=> nmi_acc_s) // [RQ2]
    else $error("nonmaskable pin not accepted first");
  nmi_hold_a: assert property (ACC_STB && ACC_SRC == ira_pkg::SRC_NMI
    |-> !$past(nmi_busy[0])) // [RQ3]
    else $error("nonmaskable pin accepted while busy");
  mask_gate_a: assert property (ACC_STB && ACC_SRC < 5'h18 && ACC_KIND != ira_pkg::KIND_MACRO
    |-> $past(GLOBAL_INT_ENABLE) && !$past(cand_mask)) // [RQ4]
    else $error("maskable vectored taken while disabled or masked");
  tie_order_a: assert property (take_mask && eligible[0]
    |-> sidx == 5'h00 || cand_lvl < level_field[0]) // [RQ5]
    else $error("lower order source skipped");
  in_service_levels_record_a: assert property (in_service_levels_set_en && !handler_return_instr_mask
    |=> in_service_levels[$past(cand_lvl)]) // [RQ19]
    else $error("accepted level not recorded");
  macro_free_a: assert property (ACC_STB && ACC_KIND == ira_pkg::KIND_MACRO && !$past(HANDLER_RETURN_INSTR_EXEC)
    |-> !ACC_PUSH && $stable(in_service_levels)) // [RQ14]
    else $error("macro service touched context");
  csi1_addr_a: assert property (ACC_STB && ACC_SRC == 5'h16
    |-> ACC_MSCW == 16'hfe32 &&
        ACC_VECTOR == ($past(VECTOR_TABLE_SELECT) ? 16'h8032 : 16'h0032)) // [RQ16]
    else $error("serial channel 1 addresses wrong");
  flag_clear_a: assert property (take_mask && !SRC_REQ[sidx] && !WR_STB && !MS_END
    |=> !req_flag[$past(sidx)]) // [RQ22]
    else $error("request flag not cleared on acceptance");
  trap_seen_a: assert property (PROT_WR_FAIL |=> trap_pend || ACC_SRC == ira_pkg::SRC_TRAP) // [RQ10]
    else $error("op-code trap lost");
  soft_break_bank_switch_bank_a: assert property (ACC_STB && ACC_SRC == ira_pkg::SRC_SOFT_BREAK_BANK_SWITCH
    |-> ACC_KIND == ira_pkg::KIND_BANK && !ACC_PUSH) // [RQ9]
    else $error("bank switch break mis-serviced");
  handler_return_instr_drop_a: assert property (handler_return_instr_mask && in_service_levels != 4'h0 && !in_service_levels_set_en
    |=> $countones(in_service_levels) + 1 == $countones($past(in_service_levels))) // [RQ13]
    else $error("return did not release one level");
endmodule
`default_nettype wire

// [shared/ira_pkg.sv]
/*
  constants of the interrupt request arbiter: register map, field
  positions, reset values, source codes, vector and control word bases.
  assumes a 16-bit register port and 24 maskable sources.
*/
`default_nettype none
package ira_pkg;
  // ****************************************
  // register map (index on the address port)
  // ****************************************
  localparam int NSRC = 24;
  localparam logic [7:0] ADDR_MASK_LO = 8'h18;
  localparam logic [7:0] ADDR_MASK_HI = 8'h19;
  localparam logic [7:0] ADDR_IN_SERVICE_LEVELS = 8'h1a;
  localparam logic [7:0] ADDR_IMC = 8'h1b;
  localparam logic [7:0] ADDR_MASK_B0 = 8'h1c;
  localparam logic [7:0] ADDR_MASK_B1 = 8'h1d;
  localparam logic [7:0] ADDR_MASK_B2 = 8'h1e;
  // ****************************************
  // per-source control register fields
  // ****************************************
  localparam int BIT_IF = 7;
  localparam int BIT_MK = 6;
  localparam int BIT_ISM = 5;
  localparam int BIT_CSE = 4;
  localparam logic [7:0] CTRL_RESET = 8'h43;
  localparam logic IMC_RESET = 1'b1;
  // ****************************************
  // source codes and addresses
  // ****************************************
  localparam logic [4:0] SRC_NMI = 5'h18;
  localparam logic [4:0] SRC_WDT = 5'h19;
  localparam logic [4:0] SRC_TRAP = 5'h1a;
  localparam logic [4:0] SRC_BRK = 5'h1b;
  localparam logic [4:0] SRC_SOFT_BREAK_BANK_SWITCH = 5'h1c;
  localparam logic [15:0] VEC_NMI = 16'h0002;
  localparam logic [15:0] VEC_WDT = 16'h0004;
  localparam logic [15:0] VEC_TRAP = 16'h003c;
  localparam logic [15:0] VEC_BRK = 16'h003e;
  localparam logic [15:0] VEC_MASK_BASE = 16'h0006;
  localparam logic [15:0] VEC_HI_TABLE = 16'h8000;
  localparam logic [15:0] MSCW_BASE = 16'hfe06;
  typedef enum logic [1:0] {
    KIND_VECT = 2'b00,
    KIND_BANK = 2'b01,
    KIND_MACRO = 2'b10
  } ira_kind_type;
endpackage
`default_nettype wire

// [hw/ira_pin_sync.sv]
/*
  two-stage synchroniser for an asynchronous pin.
  assumes the pin is a slow level; output lags by two clocks.
*/
`timescale 1ns/10ps
`default_nettype none
module ira_pin_sync
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pin,
  output logic sync
);
  logic meta;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta <= 1'b0;
      sync <= 1'b0;
    end
    else
    begin
      meta <= pin;
      sync <= meta;
    end
  end
endmodule
`default_nettype wire

// [verif/ira_core_model.sv]
/*
  core model for the interrupt request arbiter: readiness to take an
  acceptance, handler return pulses and the end of a macro transfer.
  assumes it shares CLK_SYS and RST_B with the arbiter.
*/
`timescale 1ns/10ps
`default_nettype none
module ira_core_model
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic stall,
  input wire logic ret_cmd,
  input wire logic ms_finish,
  input wire logic acc_stb,
  input wire logic [1:0] acc_kind,
  input wire logic [4:0] acc_src,
  output logic core_ready,
  output logic handler_return_instr_exec,
  output logic ms_end,
  output logic [4:0] ms_end_src
);
  logic [2:0] ms_cnt;
  logic [4:0] ms_src;
  // ****************************************
  // core side
  // ****************************************
  assign core_ready = ~stall;
  // source index shown only with the end pulse
  assign ms_end_src = ms_end ? ms_src : ~ms_src;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      handler_return_instr_exec <= 1'b0;
      ms_end <= 1'b0;
      ms_cnt <= 3'h0;
      ms_src <= 5'h00;
    end
    else
    begin
      handler_return_instr_exec <= ret_cmd;
      ms_end <= 1'b0;
      if (acc_stb && acc_kind == ira_pkg::KIND_MACRO)
      begin
        ms_cnt <= 3'h4;
        ms_src <= acc_src;
      end
      else if (ms_cnt != 3'h0)
      begin
        ms_cnt <= ms_cnt - 3'h1;
        ms_end <= (ms_cnt == 3'h1) & ms_finish;
      end
    end
  end
endmodule
`default_nettype wire

// [verif/test_interrupt_request_arbiter.sv]
/*
  self-checking bench of the interrupt request arbiter.
  assumes the core model file is compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module test_interrupt_request_arbiter;
  logic CLK_SYS = 1'b0, RST_B = 1'b0, WR_STB = 1'b0, RD_STB = 1'b0;
  logic [7:0] ADDR = 8'h00;
  logic [15:0] WR_DATA = 16'h0000, RD_DATA, ACC_VECTOR, ACC_MSCW;
  logic [23:0] SRC_REQ = 24'h000000;
  logic NMI_PIN = 1'b0, WDT_OVF = 1'b0, PROT_WR_FAIL = 1'b0, BRK_EXEC = 1'b0;
  logic SOFT_BREAK_BANK_SWITCH_EXEC = 1'b0, ie = 1'b1, tps = 1'b0, stall = 1'b0, ret_cmd = 1'b0;
  logic ms_fin = 1'b1, handler_return_instr, ready, ms_end, ACC_STB, ACC_PUSH;
  logic [4:0] ms_src, ACC_SRC;
  logic [1:0] ACC_KIND;
  logic [4:0] a_src [64];
  logic [1:0] a_kind [64];
  logic [15:0] a_vec [64], a_mscw [64];
  logic a_push [64];
  int n_mismatch = 0, n_checks = 0, n_acc = 0, n_exp = 0;
  ira_arbiter DUT (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .ADDR(ADDR), .WR_DATA(WR_DATA),
    .WR_STB(WR_STB), .RD_STB(RD_STB), .RD_DATA(RD_DATA), .SRC_REQ(SRC_REQ),
    .NMI_PIN(NMI_PIN), .WDT_OVF(WDT_OVF), .PROT_WR_FAIL(PROT_WR_FAIL),
    .BRK_EXEC(BRK_EXEC), .SOFT_BREAK_BANK_SWITCH_EXEC(SOFT_BREAK_BANK_SWITCH_EXEC), .HANDLER_RETURN_INSTR_EXEC(handler_return_instr),
    .GLOBAL_INT_ENABLE(ie), .VECTOR_TABLE_SELECT(tps), .CORE_READY(ready),
    .MS_END(ms_end), .MS_END_SRC(ms_src), .ACC_STB(ACC_STB), .ACC_KIND(ACC_KIND),
    .ACC_SRC(ACC_SRC), .ACC_VECTOR(ACC_VECTOR), .ACC_MSCW(ACC_MSCW), .ACC_PUSH(ACC_PUSH));
  ira_core_model core (.clk(CLK_SYS), .rst_b(RST_B), .stall(stall), .ret_cmd(ret_cmd),
    .ms_finish(ms_fin), .acc_stb(ACC_STB), .acc_kind(ACC_KIND), .acc_src(ACC_SRC),
    .core_ready(ready), .handler_return_instr_exec(handler_return_instr), .ms_end(ms_end), .ms_end_src(ms_src));
  // ****************************************
  // clock, acceptance log, watchdog
  // ****************************************
  initial
  begin
    forever #2.5 CLK_SYS = ~CLK_SYS;
  end
  always @(posedge CLK_SYS)
  begin
    if (ACC_STB === 1'b1 && n_acc < 64)
    begin
      a_src[n_acc] <= ACC_SRC;
      a_kind[n_acc] <= ACC_KIND;
      a_vec[n_acc] <= ACC_VECTOR;
      a_mscw[n_acc] <= ACC_MSCW;
      a_push[n_acc] <= ACC_PUSH;
      n_acc <= n_acc + 1;
    end
  end
  initial
  begin
    repeat (4000) @(posedge CLK_SYS);
    n_mismatch++;
    complete_run();
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge CLK_SYS);
    ADDR <= a;
    WR_DATA <= d;
    WR_STB <= 1'b1;
    @(posedge CLK_SYS);
    WR_STB <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge CLK_SYS);
    ADDR <= a;
    RD_STB <= 1'b1;
    @(posedge CLK_SYS);
    RD_STB <= 1'b0;
    #1 chk("read data", e, RD_DATA);
    @(posedge CLK_SYS);
    #1 chk("read idle", 16'h0000, RD_DATA);
  endtask
  // w bits: watchdog, trap, break, break bank, return
  task automatic fire(input logic [23:0] s, input logic [4:0] w);
    @(posedge CLK_SYS);
    SRC_REQ <= s;
    {WDT_OVF, PROT_WR_FAIL, BRK_EXEC, SOFT_BREAK_BANK_SWITCH_EXEC, ret_cmd} <= w;
    @(posedge CLK_SYS);
    SRC_REQ <= 24'h000000;
    {WDT_OVF, PROT_WR_FAIL, BRK_EXEC, SOFT_BREAK_BANK_SWITCH_EXEC, ret_cmd} <= 5'h00;
  endtask
  task automatic no_acc(input int n);
    repeat (n) @(posedge CLK_SYS);
    #1 chk("accept count", 16'(n_exp), 16'(n_acc));
  endtask
  task automatic wait_acc(input logic [4:0] s, input logic [1:0] k,
    input logic [15:0] v, input logic p);
    for (int i = 0; i < 30 && n_acc <= n_exp; i++) @(posedge CLK_SYS);
    #1 chk("accepted", 16'(n_exp + 1), 16'(n_acc));
    chk("source", {11'h0, s}, {11'h0, a_src[n_exp]});
    chk("kind", {14'h0, k}, {14'h0, a_kind[n_exp]});
    chk("push", {15'h0, p}, {15'h0, a_push[n_exp]});
    if (k != ira_pkg::KIND_MACRO)
      chk("vector", v, a_vec[n_exp]);
    if (s < 5'd24)
      chk("control word", ira_pkg::MSCW_BASE + {10'h0, s, 1'b0}, a_mscw[n_exp]);
    n_exp++;
  endtask
  function automatic logic [15:0] vec(input logic [4:0] s);
    return ira_pkg::VEC_MASK_BASE + {10'h0, s, 1'b0};
  endfunction
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_mask();
    rd(ira_pkg::ADDR_MASK_LO, 16'hffff);
    rd(8'h05, 16'h0043);
    wr(8'h05, 16'h0001);
    rd(ira_pkg::ADDR_MASK_LO, 16'hffdf);
    wr(ira_pkg::ADDR_MASK_B0, 16'h00ff);
    rd(8'h05, 16'h0041);
    fire(24'h000020, 5'h00);
    no_acc(6);
    rd(8'h05, 16'h00c1);
    wr(ira_pkg::ADDR_MASK_LO, 16'hffdf);
    wait_acc(5'd5, ira_pkg::KIND_VECT, vec(5'd5), 1'b1);
    rd(8'h05, 16'h0001);
    rd(ira_pkg::ADDR_IN_SERVICE_LEVELS, 16'h0002);
    fire(24'h0, 5'h01);
    rd(ira_pkg::ADDR_IN_SERVICE_LEVELS, 16'h0000);
  endtask
  task automatic t_walk();
    wr(8'h16, 16'h0003);
    stall <= 1'b1;
    fire(24'h400000, 5'h00);
    no_acc(4);
    stall <= 1'b0;
    wait_acc(5'd22, ira_pkg::KIND_VECT, 16'h0032, 1'b1);
    fire(24'h0, 5'h01);
    tps <= 1'b1;
    fire(24'h400000, 5'h00);
    wait_acc(5'd22, ira_pkg::KIND_VECT, 16'h8032, 1'b1);
    fire(24'h0, 5'h01);
    tps <= 1'b0;
  endtask
  task automatic t_level();
    wr(8'h01, 16'h0001);
    wr(8'h03, 16'h0001);
    wr(8'h04, 16'h0002);
    wr(8'h06, 16'h0000);
    fire(24'h00001a, 5'h00);
    wait_acc(5'd1, ira_pkg::KIND_VECT, vec(5'd1), 1'b1);
    no_acc(6);
    fire(24'h000040, 5'h00);
    wait_acc(5'd6, ira_pkg::KIND_VECT, vec(5'd6), 1'b1);
    rd(ira_pkg::ADDR_IN_SERVICE_LEVELS, 16'h0003);
    fire(24'h0, 5'h01);
    rd(ira_pkg::ADDR_IN_SERVICE_LEVELS, 16'h0002);
    fire(24'h0, 5'h01);
    wait_acc(5'd3, ira_pkg::KIND_VECT, vec(5'd3), 1'b1);
    fire(24'h0, 5'h01);
    wait_acc(5'd4, ira_pkg::KIND_VECT, vec(5'd4), 1'b1);
    fire(24'h0, 5'h01);
  endtask
  task automatic t_nmi();
    wr(8'h00, 16'h0000);
    fire(24'h000001, 5'h10);
    wait_acc(5'd25, ira_pkg::KIND_VECT, 16'h0004, 1'b1);
    NMI_PIN <= 1'b1;
    wait_acc(5'd24, ira_pkg::KIND_VECT, 16'h0002, 1'b1);
    fire(24'h0, 5'h10);
    no_acc(4);
    fire(24'h0, 5'h01);
    no_acc(4);
    fire(24'h0, 5'h01);
    wait_acc(5'd25, ira_pkg::KIND_VECT, 16'h0004, 1'b1);
    fire(24'h0, 5'h01);
    wait_acc(5'd0, ira_pkg::KIND_VECT, vec(5'd0), 1'b1);
    fire(24'h0, 5'h01);
    NMI_PIN <= 1'b0;
  endtask
  task automatic t_soft();
    ie <= 1'b0;
    fire(24'h0, 5'h08);
    wait_acc(5'd26, ira_pkg::KIND_VECT, 16'h003c, 1'b1);
    fire(24'h0, 5'h04);
    wait_acc(5'd27, ira_pkg::KIND_VECT, 16'h003e, 1'b1);
    fire(24'h0, 5'h02);
    wait_acc(5'd28, ira_pkg::KIND_BANK, 16'h003e, 1'b0);
  endtask
  task automatic t_macro();
    wr(8'h07, 16'h0023);
    fire(24'h000080, 5'h00);
    wait_acc(5'd7, ira_pkg::KIND_MACRO, 16'h0, 1'b0);
    no_acc(10);
    ie <= 1'b1;
    wait_acc(5'd7, ira_pkg::KIND_VECT, vec(5'd7), 1'b1);
    rd(8'h07, 16'h0003);
    fire(24'h0, 5'h01);
    wr(8'h09, 16'h0012);
    fire(24'h000200, 5'h00);
    wait_acc(5'd9, ira_pkg::KIND_BANK, vec(5'd9), 1'b0);
    rd(ira_pkg::ADDR_IN_SERVICE_LEVELS, 16'h0004);
    fire(24'h0, 5'h01);
  endtask
  initial
  begin
    repeat (20) @(posedge CLK_SYS);
    RST_B <= 1'b1;
    t_mask();
    t_walk();
    t_level();
    t_nmi();
    t_soft();
    t_macro();
    complete_run();
  end
endmodule
`default_nettype wire
